// *** design/stack_monitor_pin_control.sv ***
// pin level control: watchdog, general pins, straps, serial output, temperature store
`timescale 1ns/1ns
`default_nettype none
// How it works
// - silent host for timeout raises watchdog alarm
// - alarm forces configuration back to defaults
// - alarm pin is open-drain low only
// - general pin bit zero pulls pin low
// - general pin bit one releases pin
// - general pin reads return sampled pin level
// - address formed from four synchronised straps
// - top-of-stack strap changes toggle polling sense
// - temperature conversions stored in result register one or two, chosen by temp_conv_sel
// - serial output drives low only, open-drain
// - twelve discharge switch outputs, one per cell
// - watchdog expiry turns all discharge switches off
// - toggle polling shows status as square wave
module stack_monitor_pin_control #(
   parameter int unsigned WDT_CYCLES = stack_pin_pkg::WDT_CYCLES,
   parameter int unsigned TOGGLE_HALF_CYCLES = stack_pin_pkg::TOGGLE_HALF_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic valid_cmd,
   input wire logic cfg_wr,
   input wire logic [stack_pin_pkg::NUM_GPIO-1:0] cfg_gpio_wdata,
   input wire logic [stack_pin_pkg::NUM_CELLS-1:0] cfg_discharge_wdata,
   output logic [stack_pin_pkg::NUM_GPIO-1:0] cfg_gpio_rdata,
   output logic [stack_pin_pkg::NUM_CELLS-1:0] discharge_switch_outputs,
   output logic watchdog_alarm_n_o,
   output logic watchdog_alarm_n_oe_n,
   output logic watchdog_active,
   input wire logic general_pin_one_i,
   output logic general_pin_one_o,
   output logic general_pin_one_oe_n,
   input wire logic general_pin_two_i,
   output logic general_pin_two_o,
   output logic general_pin_two_oe_n,
   input wire logic addr_strap_bit_zero,
   input wire logic addr_strap_bit_one,
   input wire logic addr_strap_bit_two,
   input wire logic addr_strap_bit_three,
   output logic [stack_pin_pkg::ADDR_W-1:0] device_address,
   input wire logic top_of_stack_strap,
   output logic top_of_stack,
   input wire logic chip_select_n,
   output logic selected,
   input wire logic poll_enable,
   input wire logic toggle_mode,
   input wire logic poll_status,
   input wire logic shift_bit,
   output logic serial_data_out_o,
   output logic serial_data_out_oe_n,
   input wire logic temp_conv_valid,
   input wire logic temp_conv_sel,
   input wire logic [stack_pin_pkg::ADC_W-1:0] temp_conv_data,
   output logic [stack_pin_pkg::ADC_W-1:0] temperature_result_reg_one,
   output logic [stack_pin_pkg::ADC_W-1:0] temperature_result_reg_two
);
   import stack_pin_pkg::*;

   typedef struct packed {
      logic [NUM_GPIO-1:0] gpio_s1;
      logic [NUM_GPIO-1:0] gpio_s2;
      logic [ADDR_W-1:0] addr_s1;
      logic [ADDR_W-1:0] addr_s2;
      logic tos_s1;
      logic tos_s2;
      logic cs_s1;
      logic cs_s2;
      logic [NUM_GPIO-1:0] cfg_gpio;
      logic [NUM_CELLS-1:0] cfg_discharge;
      logic alarm;
      logic alarm_oe_n;
      logic square;
      logic sdo_oe_n;
      logic [ADC_W-1:0] temp_one;
      logic [ADC_W-1:0] temp_two;
   } pin_state_t;

   localparam pin_state_t STATE_RST = '{
      gpio_s1: '0, gpio_s2: '0, addr_s1: ADDR_RST, addr_s2: ADDR_RST,
      tos_s1: 1'b0, tos_s2: 1'b0, cs_s1: 1'b1, cs_s2: 1'b1,
      cfg_gpio: CFG_GPIO_RST, cfg_discharge: CFG_DISCHARGE_RST,
      alarm: 1'b0, alarm_oe_n: 1'b1, square: 1'b0, sdo_oe_n: 1'b1,
      temp_one: TEMP_RST, temp_two: TEMP_RST
   };

   pin_state_t s_q, s_d;
   logic wdt_tick;
   logic half_tick;
   logic status_shown;
   logic drive_low;

   ////////////////////////////////////////////////////////////////////////////
   // timers

   tick_divider #(
      .COUNT(WDT_CYCLES)
   ) u_watchdog (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(valid_cmd),
      .tick(wdt_tick)
   );

   tick_divider #(
      .COUNT(TOGGLE_HALF_CYCLES)
   ) u_toggle (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(1'b0),
      .tick(half_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      status_shown = 1'b0;
      drive_low = 1'b0;
      // pin synchronisers
      s_d.gpio_s1 = {general_pin_two_i, general_pin_one_i};
      s_d.gpio_s2 = s_q.gpio_s1;
      s_d.addr_s1 = {addr_strap_bit_three, addr_strap_bit_two,
                     addr_strap_bit_one, addr_strap_bit_zero};
      s_d.addr_s2 = s_q.addr_s1;
      s_d.tos_s1 = top_of_stack_strap;
      s_d.tos_s2 = s_q.tos_s1;
      s_d.cs_s1 = chip_select_n;
      s_d.cs_s2 = s_q.cs_s1;
      // watchdog alarm
      if (valid_cmd) begin
         s_d.alarm = 1'b0;
      end else if (wdt_tick) begin
         s_d.alarm = 1'b1;
      end
      s_d.alarm_oe_n = ~s_d.alarm;
      // configuration store
      if (s_q.alarm && !valid_cmd) begin
         s_d.cfg_gpio = CFG_GPIO_RST;
         s_d.cfg_discharge = CFG_DISCHARGE_RST;
      end else if (cfg_wr) begin
         s_d.cfg_gpio = cfg_gpio_wdata;
         s_d.cfg_discharge = cfg_discharge_wdata;
      end
      // square wave for toggle polling
      if (half_tick) begin
         s_d.square = ~s_q.square;
      end
      // serial output, driven only while selected
      status_shown = poll_status ^ ~s_q.tos_s2;
      if (poll_enable) begin
         if (toggle_mode) begin
            drive_low = status_shown & s_q.square;
         end else begin
            drive_low = ~poll_status;
         end
      end else begin
         drive_low = ~shift_bit;
      end
      s_d.sdo_oe_n = ~(drive_low & ~s_q.cs_s2);
      // temperature results
      if (temp_conv_valid) begin
         if (temp_conv_sel) begin
            s_d.temp_two = temp_conv_data;
         end else begin
            s_d.temp_one = temp_conv_data;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign cfg_gpio_rdata = s_q.gpio_s2;
   assign discharge_switch_outputs = s_q.cfg_discharge;
   assign watchdog_alarm_n_o = 1'b0;
   assign watchdog_alarm_n_oe_n = s_q.alarm_oe_n;
   assign watchdog_active = s_q.alarm;
   assign general_pin_one_o = 1'b0;
   assign general_pin_one_oe_n = s_q.cfg_gpio[0];
   assign general_pin_two_o = 1'b0;
   assign general_pin_two_oe_n = s_q.cfg_gpio[1];
   assign device_address = s_q.addr_s2;
   assign top_of_stack = s_q.tos_s2;
   assign selected = ~s_q.cs_s2;
   assign serial_data_out_o = 1'b0;
   assign serial_data_out_oe_n = s_q.sdo_oe_n;
   assign temperature_result_reg_one = s_q.temp_one;
   assign temperature_result_reg_two = s_q.temp_two;
endmodule
`default_nettype wire

// *** design/stack_pin_pkg.sv ***
// shared constants for the stack monitor pin control block
package stack_pin_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned WDT_MIN_MS = 1000;
   localparam int unsigned WDT_MAX_MS = 2500;
   localparam int unsigned WDT_TIMEOUT_MS = 1500;
   localparam int unsigned WDT_CYCLES = (CLK_HZ / 1000) * WDT_TIMEOUT_MS;
   localparam int unsigned TOGGLE_HZ = 1000;
   localparam int unsigned TOGGLE_HALF_CYCLES = CLK_HZ / (2 * TOGGLE_HZ);
   localparam int unsigned NUM_CELLS = 12;
   localparam int unsigned NUM_GPIO = 2;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned ADC_W = 12;
   localparam logic [1:0] CFG_GPIO_RST = 2'h3;
   localparam logic [11:0] CFG_DISCHARGE_RST = 12'h000;
   localparam logic [11:0] TEMP_RST = 12'h000;
   localparam logic [3:0] ADDR_RST = 4'h0;
endpackage

// *** design/tick_divider.sv ***
// counter that emits a one-cycle tick every COUNT cycles, restarted by clear
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
   parameter int unsigned COUNT = 1000
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clear,
   output logic tick
);
   localparam int unsigned CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } div_state_t;

   div_state_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (clear) begin
         s_d.cnt = '0;
      end else if (s_q.cnt == LAST) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule
`default_nettype wire

// *** verif/pin_control_props.sv ***
// checker for the stack monitor pin control ports
`timescale 1ns/1ns
`default_nettype none
module pin_control_props #(parameter int unsigned WDT_CYCLES = 50) (
   input wire logic ref_clk, reset, valid_cmd, cfg_wr, watchdog_active, watchdog_alarm_n_o,
   input wire logic watchdog_alarm_n_oe_n, serial_data_out_o, serial_data_out_oe_n, selected,
   input wire logic general_pin_one_o, general_pin_two_o, general_pin_one_oe_n,
   input wire logic general_pin_two_oe_n, general_pin_one_i, general_pin_two_i,
   input wire logic poll_enable, toggle_mode, poll_status, top_of_stack,
   input wire logic temp_conv_valid, temp_conv_sel,
   input wire logic [1:0] cfg_gpio_wdata, cfg_gpio_rdata,
   input wire logic [11:0] cfg_discharge_wdata, discharge_switch_outputs, temp_conv_data,
   input wire logic [11:0] temperature_result_reg_one, temperature_result_reg_two
);
   logic [31:0] cnt_q;
   logic [2:0] age_q;
   wire [1:0] pins = {general_pin_two_i, general_pin_one_i};
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= '0;
         age_q <= '0;
      end else begin
         cnt_q <= valid_cmd ? '0 : cnt_q + 32'h0000_0001;
         age_q <= age_q + {2'h0, age_q != 3'h7};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_wdt_timeout: assert property (watchdog_active == (cnt_q > WDT_CYCLES))
      else $error("alarm timing wrong");
   chk_wdt_defaults: assert property (watchdog_active && !valid_cmd |=>
      !discharge_switch_outputs && general_pin_one_oe_n && general_pin_two_oe_n)
      else $error("defaults not restored");
   chk_open_drain: assert property (!watchdog_alarm_n_o && !serial_data_out_o
      && !general_pin_one_o && !general_pin_two_o && watchdog_alarm_n_oe_n == !watchdog_active)
      else $error("open drain pin wrong");
   chk_cfg_take: assert property (cfg_wr && (!watchdog_active || valid_cmd) |=>
      {general_pin_two_oe_n, general_pin_one_oe_n} == $past(cfg_gpio_wdata)
      && discharge_switch_outputs == $past(cfg_discharge_wdata)) else $error("config write lost");
   chk_pin_readback: assert property ((age_q == 3'h7 && $stable(pins))[*4] |-> cfg_gpio_rdata == pins)
      else $error("pin readback wrong");
   chk_toggle_sense: assert property (poll_enable && toggle_mode && poll_status != top_of_stack |=>
      serial_data_out_oe_n) else $error("toggle sense wrong");
   chk_idle_release: assert property (!selected |=> serial_data_out_oe_n)
      else $error("serial out driven while idle");
   chk_temp_store: assert property (temp_conv_valid |=> $past(temp_conv_data) ==
      ($past(temp_conv_sel) ? temperature_result_reg_two : temperature_result_reg_one))
      else $error("temperature not stored");
endmodule
bind stack_monitor_pin_control pin_control_props #(.WDT_CYCLES(WDT_CYCLES)) props (.*);
`default_nettype wire

// *** verif/pin_pullups.sv ***
// external pull-ups on the general pins and serial output, loads on the two general pins only
`timescale 1ns/1ns
`default_nettype none
module pin_pullups (
   input wire logic one_oe_n, two_oe_n, sdo_oe_n,
   input wire logic [1:0] ext_low,
   output logic one_level, two_level, sdo_level
);
   assign one_level = one_oe_n & ~ext_low[0];
   assign two_level = two_oe_n & ~ext_low[1];
   assign sdo_level = sdo_oe_n;
endmodule
`default_nettype wire

// *** verif/stack_monitor_pin_control_test.sv ***
// self-checking bench for the stack monitor pin control block
`timescale 1ns/1ns
`default_nettype none
module stack_monitor_pin_control_test;
   logic ref_clk = 0, reset = 1, valid_cmd = 0, cfg_wr = 0, poll_enable = 0, toggle_mode = 0;
   logic poll_status = 0, shift_bit = 0, chip_select_n = 1, top_of_stack_strap = 0;
   logic temp_conv_valid = 0, temp_conv_sel = 0, addr_strap_bit_zero = 0, addr_strap_bit_one = 0;
   logic addr_strap_bit_two = 0, addr_strap_bit_three = 0, watchdog_alarm_n_o, watchdog_active;
   logic watchdog_alarm_n_oe_n, general_pin_one_i, general_pin_one_o, general_pin_one_oe_n;
   logic general_pin_two_i, general_pin_two_o, general_pin_two_oe_n, top_of_stack, selected;
   logic serial_data_out_o, serial_data_out_oe_n, sdo_line;
   logic [1:0] cfg_gpio_wdata = 0, cfg_gpio_rdata, ext_low = 0;
   logic [3:0] device_address;
   logic [11:0] cfg_discharge_wdata = 0, discharge_switch_outputs, temp_conv_data = 0;
   logic [11:0] temperature_result_reg_one, temperature_result_reg_two;
   integer seed = 26939, error_cnt = 0, samples_checked = 0, i, n;
   always #4 ref_clk = ~ref_clk;
   stack_monitor_pin_control #(.WDT_CYCLES(50), .TOGGLE_HALF_CYCLES(4)) uut (.*);
   pin_pullups host (.one_oe_n(general_pin_one_oe_n), .two_oe_n(general_pin_two_oe_n),
      .sdo_oe_n(serial_data_out_oe_n), .ext_low(ext_low), .one_level(general_pin_one_i),
      .two_level(general_pin_two_i), .sdo_level(sdo_line));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic cfg(input logic [1:0] g, input logic [11:0] d, input logic v);
      @(posedge ref_clk);
      {cfg_wr, valid_cmd, cfg_gpio_wdata, cfg_discharge_wdata} <= {1'b1, v, g, d};
      @(posedge ref_clk);
      {cfg_wr, valid_cmd} <= 2'h0;
   endtask
   function automatic int exp_lows(input logic [5:0] m);
      if (m[5]) return 0;
      if (!m[0]) return m[3] ? 0 : 16;
      if (!m[1]) return m[2] ? 0 : 16;
      return (m[2] == m[4]) ? 8 : 0;
   endfunction
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      error_cnt++;
      summarize;
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 0;
      cfg(2'h2, 12'habc, 1);
      tick(0);
      chk(discharge_switch_outputs, 12'habc);
      tick(50);
      chk(watchdog_active, 0);
      tick(1);
      chk({watchdog_active, watchdog_alarm_n_oe_n}, 2'h2);
      tick(1);
      chk({general_pin_two_oe_n, general_pin_one_oe_n, discharge_switch_outputs}, 14'h3000);
      cfg(2'h0, 12'hfff, 0);
      tick(0);
      chk(discharge_switch_outputs, 0);
      cfg(2'h1, 12'h00f, 1);
      tick(0);
      chk({watchdog_active, discharge_switch_outputs}, 13'h000f);
      $display("watchdog test done");
      for (i = 0; i < 20; i++) begin
         n = $random(seed);
         cfg(n[1:0], n[13:2], 1);
         ext_low <= n[15:14];
         tick(4);
         chk({general_pin_two_oe_n, general_pin_one_oe_n}, n[1:0]);
         chk(cfg_gpio_rdata, n[1:0] & ~n[15:14]);
      end
      $display("general pin test done");
      for (i = 0; i < 8; i++) begin
         n = (i == 0) ? 15 : $random(seed);
         @(posedge ref_clk);
         {top_of_stack_strap, addr_strap_bit_three, addr_strap_bit_two} <= n[4:2];
         {addr_strap_bit_one, addr_strap_bit_zero} <= n[1:0];
         tick(4);
         chk({top_of_stack, device_address}, n[4:0]);
      end
      $display("strap test done");
      for (i = 0; i < 64; i++) begin
         @(posedge ref_clk);
         {chip_select_n, top_of_stack_strap, shift_bit} <= i[5:3];
         {poll_status, toggle_mode, poll_enable} <= i[2:0];
         tick(6);
         n = 0;
         repeat (16) begin
            @(negedge ref_clk);
            n += !sdo_line;
         end
         chk(n, exp_lows(i[5:0]));
      end
      $display("serial output test done");
      for (i = 0; i < 10; i++) begin
         n = (i < 2) ? 12'hfff : $random(seed);
         @(posedge ref_clk);
         {temp_conv_valid, temp_conv_sel, temp_conv_data} <= {1'b1, i[0], n[11:0]};
         @(posedge ref_clk);
         temp_conv_valid <= 0;
         tick(0);
         chk(i[0] ? temperature_result_reg_two : temperature_result_reg_one, n[11:0]);
      end
      $display("temperature test done");
      summarize;
   end
endmodule
`default_nettype wire
